// file: rfm_addr_map.sv
// address-space logic: program counter map and paged register decode
// assumes the cpu gives a mode qualifier with every register access
// Functional notes
// - 16-bit fetch address, 48K program memory
// - 8-bit register bus carries address, data
// - fetch starts at 0100H after reset
// - vector area 0H-0FFH is ordinary memory
// - 256 physical bytes decode to 320
// - set 1 only via register modes
// - E0H-FFH banked, reset picks bank 0
// - D0H-DFH system, C0H-CFH common area
// - common area only by working addressing
// - set 2 per page via indirect/indexed
// - 00H-BFH prime area on eight pages
// - page pointer at DFH, reset zero
// - display data registers lie in prime area
// - slice is 8 bytes, upper five bits
// - slice pointers at D6H, D7H, loadable
// - reset pointers select C0H and C8H
// - working addressing never reaches set 2
// - combined set loads operand and operand+8
// - bit 3 picks pointer, join bits
// - 8-bit address 1100B nibble means working in register mode
// - register pair even MSB, odd LSB
`timescale 1ns/1ps
`default_nettype none
module rfm_addr_map
    import rfm_pkg::*;
(
    input wire logic clk, // 25 MHz core clock
    input wire logic srst, // synchronous reset, active high
    // program memory side
    input wire logic pc_load, // jump/vector load strobe
    input wire logic [15:0] pc_load_val, // new fetch address
    input wire logic pc_step, // advance fetch address
    output logic [15:0] fetch_addr, // fetch address
    output logic fetch_valid, // fetch inside program memory
    output logic fetch_in_vec, // fetch in vector area
    // register bus side
    input wire logic rb_req, // register access request
    input wire logic rb_we, // 1 write, 0 read
    input wire logic rb_pair, // 16-bit pair access
    input wire logic [2:0] rb_mode, // addressing-mode qualifier
    input wire logic rb_short, // address is 4-bit working form
    input wire logic [7:0] rb_addr, // register address
    input wire logic [7:0] rb_wdata, // write data
    output logic [7:0] rb_rdata, // read data for pointer registers
    output logic rb_hit_ptr, // access served by pointer registers
    // instruction side
    input wire logic bank_zero_select_instr, // select bank 0
    input wire logic bank_one_select_instr, // select bank 1
    input wire logic set_both_slice_pointers, // load both pointers
    input wire logic set_first_slice_pointer, // load first pointer
    input wire logic set_second_slice_pointer, // load second pointer
    input wire logic [7:0] srp_operand, // pointer operand
    // physical decode outputs
    output logic [PHYS_W-1:0] phys_addr, // page, offset physical address
    output logic [PHYS_W-1:0] phys_addr_lo, // second byte of a pair
    output logic [5:0] phys_tgt, // region one-hot
    output logic phys_bank, // bank for E0H-FFH
    output logic phys_err, // illegal mode for address
    output logic phys_valid, // decoded access strobe
    output logic [7:0] slice_pointer_first, // first slice pointer
    output logic [7:0] slice_pointer_second, // second slice pointer
    output logic [7:0] page_select_pointer, // page pointer
    output logic bank_sel // current bank
);
    // ========================================================
    // program counter
    logic [15:0] pc_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_r <= RESET_PC;
        end else if (pc_load) begin
            pc_r <= pc_load_val;
        end else if (pc_step) begin
            pc_r <= pc_r + 16'h0001;
        end
    end
    assign fetch_addr = pc_r;
    assign fetch_valid = (pc_r < ROM_SIZE);
    // vector area fetches like any other program memory
    assign fetch_in_vec = (pc_r <= VEC_LAST);

    // ========================================================
    // bank select
    logic bank_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            bank_r <= 1'b0;
        end else if (bank_one_select_instr) begin
            bank_r <= 1'b1;
        end else if (bank_zero_select_instr) begin
            bank_r <= 1'b0;
        end
    end
    assign bank_sel = bank_r;

    // ========================================================
    // pointer register write decode (register mode only)
    logic set1_reg_wr;
    logic wr_sp1;
    logic wr_sp2;
    logic wr_pp;
    assign set1_reg_wr = rb_req && rb_we && !rb_short && rb_mode == RFM_MODE_REG;
    always_comb begin
        wr_sp1 = 1'b0;
        wr_sp2 = 1'b0;
        wr_pp = 1'b0;
        if (!set1_reg_wr) begin
            wr_sp1 = 1'b0;
        end else if (rb_addr == ADDR_SP_FIRST) begin
            wr_sp1 = 1'b1;
        end else if (rb_addr == ADDR_SP_SECOND) begin
            wr_sp2 = 1'b1;
        end else if (rb_addr == ADDR_PAGE_PTR) begin
            wr_pp = 1'b1;
        end
    end

    // ========================================================
    // slice pointers
    logic [7:0] sp1_r;
    logic [7:0] sp2_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            sp1_r <= RST_SP_FIRST;
        end else if (set_both_slice_pointers || set_first_slice_pointer) begin
            sp1_r <= srp_operand;
        end else if (wr_sp1) begin
            sp1_r <= rb_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            sp2_r <= RST_SP_SECOND;
        end else if (set_both_slice_pointers) begin
            sp2_r <= srp_operand + SLICE_STEP;
        end else if (set_second_slice_pointer) begin
            sp2_r <= srp_operand;
        end else if (wr_sp2) begin
            sp2_r <= rb_wdata;
        end
    end
    assign slice_pointer_first = sp1_r;
    assign slice_pointer_second = sp2_r;

    // ========================================================
    // page pointer: low nibble source, high nibble destination
    logic [7:0] pp_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            pp_r <= RST_PAGE_PTR;
        end else if (wr_pp) begin
            pp_r <= rb_wdata;
        end
    end
    assign page_select_pointer = pp_r;

    // ========================================================
    // working address forming
    logic is_work;
    logic [3:0] work_idx;
    logic [7:0] work_addr;
    // 1100B upper nibble in register mode means working reference
    assign is_work = rb_short || (rb_mode == RFM_MODE_WORK) ||
        (rb_mode == RFM_MODE_REG && rb_addr[7:4] == WORK_NIBBLE);
    assign work_idx = rb_short ? rb_addr[3:0] : rb_addr[3:0];
    rfm_work_addr u_work (
        .work_idx(work_idx),
        .sp_first(sp1_r),
        .sp_second(sp2_r),
        .reg_addr(work_addr)
    );

    // ========================================================
    // region decode
    logic [7:0] eff_addr;
    logic [PAGE_W-1:0] page;
    logic [5:0] tgt;
    logic err;
    assign eff_addr = is_work ? work_addr : rb_addr;
    // source page on reads, destination page on writes
    assign page = rb_we ? pp_r[4+PAGE_W-1:4] : pp_r[PAGE_W-1:0];
    always_comb begin
        tgt = RFM_TGT_NONE;
        err = 1'b0;
        if (eff_addr < ADDR_SET1_LO) begin
            tgt = RFM_TGT_PRIME;
        end else if (rb_mode == RFM_MODE_IND && !is_work) begin
            tgt = RFM_TGT_SET2;
        end else if (eff_addr < ADDR_SYS_LO) begin
            // common area refused unless reached by working form
            if (is_work) begin
                tgt = RFM_TGT_COMMON;
            end else begin
                err = 1'b1;
            end
        end else if (eff_addr < ADDR_BANK_LO) begin
            tgt = RFM_TGT_SYS;
        end else begin
            tgt = RFM_TGT_BANK;
        end
    end

    // ========================================================
    // registered decode results on the register bus
    logic [PHYS_W-1:0] phys_r;
    logic [PHYS_W-1:0] phys_lo_r;
    logic [5:0] tgt_r;
    logic bank_o_r;
    logic err_r;
    logic valid_r;
    logic [7:0] rdata_r;
    logic hit_r;
    logic [7:0] ptr_rd;
    logic ptr_hit;
    logic [7:0] pair_lo;
    assign pair_lo = {eff_addr[7:1], 1'b1};
    always_comb begin
        ptr_rd = 8'h00;
        ptr_hit = 1'b0;
        if (tgt != RFM_TGT_SYS) begin
            ptr_hit = 1'b0;
        end else if (eff_addr == ADDR_SP_FIRST) begin
            ptr_rd = sp1_r;
            ptr_hit = 1'b1;
        end else if (eff_addr == ADDR_SP_SECOND) begin
            ptr_rd = sp2_r;
            ptr_hit = 1'b1;
        end else if (eff_addr == ADDR_PAGE_PTR) begin
            ptr_rd = pp_r;
            ptr_hit = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            phys_r <= '0;
            phys_lo_r <= '0;
            tgt_r <= RFM_TGT_NONE;
            bank_o_r <= 1'b0;
            err_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            // even byte of a pair is the high byte
            phys_r <= {page, rb_pair ? {eff_addr[7:1], 1'b0} : eff_addr};
            phys_lo_r <= {page, pair_lo};
            tgt_r <= tgt;
            bank_o_r <= bank_r;
            err_r <= rb_req && err;
            valid_r <= rb_req && !err;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end else begin
            rdata_r <= (rb_req && !rb_we) ? ptr_rd : 8'h00;
            hit_r <= rb_req && ptr_hit;
        end
    end
    assign phys_addr = phys_r;
    assign phys_addr_lo = phys_lo_r;
    assign phys_tgt = tgt_r;
    assign phys_bank = bank_o_r;
    assign phys_err = err_r;
    assign phys_valid = valid_r;
    assign rb_rdata = rdata_r;
    assign rb_hit_ptr = hit_r;

    // ========================================================
    // checks
    a_reset_pc: assert property (@(posedge clk) $past(srst) |-> pc_r == RESET_PC)
        else $error("fetch does not start at reset address");
    a_reset_ptrs: assert property (@(posedge clk) $past(srst) |->
        sp1_r == RST_SP_FIRST && sp2_r == RST_SP_SECOND && pp_r == RST_PAGE_PTR)
        else $error("pointer reset values wrong");
    a_bank_reset: assert property (@(posedge clk) $past(srst) |-> !bank_r)
        else $error("bank not zero after reset");
    a_srp_both: assert property (@(posedge clk) disable iff (srst)
        set_both_slice_pointers |=> sp2_r == sp1_r + SLICE_STEP)
        else $error("combined pointer load wrong");
    // a same-cycle first-pointer load or bus write may legally move sp1
    a_srp_one: assert property (@(posedge clk) disable iff (srst)
        set_second_slice_pointer && !set_both_slice_pointers && !set_first_slice_pointer && !wr_sp1
        |=> $stable(sp1_r))
        else $error("single load changed other pointer");
    a_common_mode: assert property (@(posedge clk) disable iff (srst)
        rb_req && !is_work && rb_mode == RFM_MODE_REG && rb_addr >= ADDR_SET1_LO &&
        rb_addr < ADDR_SYS_LO |=> phys_err)
        else $error("direct common access not refused");
    a_work_no_set2: assert property (@(posedge clk) disable iff (srst)
        rb_req && is_work |=> tgt_r != RFM_TGT_SET2)
        else $error("working access reached set 2");
    a_page_dir: assert property (@(posedge clk) disable iff (srst)
        rb_req && !rb_we && rb_addr < ADDR_SET1_LO && !is_work |=>
        phys_r[PHYS_W-1:8] == $past(pp_r[PAGE_W-1:0]))
        else $error("read did not use source page");
    a_ind_set2: assert property (@(posedge clk) disable iff (srst)
        rb_req && rb_mode == RFM_MODE_IND && !is_work && rb_addr >= ADDR_SET1_LO |=>
        tgt_r == RFM_TGT_SET2 && valid_r)
        else $error("indirect upper access missed set 2");
    a_pc_step: assert property (@(posedge clk) disable iff (srst)
        pc_step && !pc_load |=> pc_r == $past(pc_r) + 16'h0001)
        else $error("fetch address did not advance");
    a_pc_load: assert property (@(posedge clk) disable iff (srst)
        pc_load |=> pc_r == $past(pc_load_val))
        else $error("fetch address not loaded");
    a_bank_one: assert property (@(posedge clk) disable iff (srst)
        bank_one_select_instr |=> bank_r)
        else $error("bank 1 not selected");
    a_bank_zero: assert property (@(posedge clk) disable iff (srst)
        bank_zero_select_instr && !bank_one_select_instr |=> !bank_r)
        else $error("bank 0 not selected");
    a_pp_write: assert property (@(posedge clk) disable iff (srst)
        wr_pp |=> pp_r == $past(rb_wdata))
        else $error("page pointer write lost");
    a_pair_bytes: assert property (@(posedge clk) disable iff (srst)
        rb_req && rb_pair |=> !phys_r[0] && phys_lo_r[0] && phys_r[7:1] == phys_lo_r[7:1])
        else $error("pair bytes not even then odd");
    a_work_low: assert property (@(posedge clk) disable iff (srst)
        rb_req && is_work && !rb_pair |=> phys_r[2:0] == $past(rb_addr[2:0]))
        else $error("working low bits not kept");
    a_prime_reach: assert property (@(posedge clk) disable iff (srst)
        rb_req && eff_addr < ADDR_SET1_LO |=> tgt_r == RFM_TGT_PRIME && valid_r)
        else $error("prime access not served");
    a_set1_reg: assert property (@(posedge clk) disable iff (srst)
        rb_req && rb_mode == RFM_MODE_REG && rb_addr >= ADDR_SYS_LO |=> valid_r && tgt_r != RFM_TGT_SET2)
        else $error("register mode missed set 1");
    a_ptr_read: assert property (@(posedge clk) disable iff (srst)
        rb_req && !rb_we && !rb_short && rb_mode == RFM_MODE_REG && rb_addr == ADDR_PAGE_PTR
        |=> rb_hit_ptr && rb_rdata == $past(pp_r))
        else $error("page pointer read wrong");
    a_idle_quiet: assert property (@(posedge clk) disable iff (srst)
        !rb_req |=> !phys_valid && !phys_err)
        else $error("decode strobe without request");
    c_set2: cover property (@(posedge clk) valid_r && tgt_r == RFM_TGT_SET2);
    c_bank1: cover property (@(posedge clk) valid_r && tgt_r == RFM_TGT_BANK && phys_bank);
    c_common: cover property (@(posedge clk) valid_r && tgt_r == RFM_TGT_COMMON);
    c_paged: cover property (@(posedge clk) valid_r && phys_r[PHYS_W-1:8] != '0);
endmodule
`default_nettype wire

// file: rfm_pkg.sv
// package for the paged register file address map
// assumes one 25 MHz core clock and a synchronous active-high reset
package rfm_pkg;
    // ========================================================
    // program memory map
    localparam int PC_W = 16;
    localparam logic [15:0] ROM_SIZE = 16'hc000;
    localparam logic [15:0] RESET_PC = 16'h0100;
    localparam logic [15:0] VEC_LAST = 16'h00ff;
    // ========================================================
    // register file map
    localparam logic [7:0] ADDR_SET1_LO = 8'hc0;
    localparam logic [7:0] ADDR_SYS_LO = 8'hd0;
    localparam logic [7:0] ADDR_BANK_LO = 8'he0;
    localparam logic [7:0] ADDR_SP_FIRST = 8'hd6;
    localparam logic [7:0] ADDR_SP_SECOND = 8'hd7;
    localparam logic [7:0] ADDR_PAGE_PTR = 8'hdf;
    localparam logic [7:0] RST_SP_FIRST = 8'hc0;
    localparam logic [7:0] RST_SP_SECOND = 8'hc8;
    localparam logic [7:0] RST_PAGE_PTR = 8'h00;
    localparam logic [7:0] SLICE_STEP = 8'h08;
    localparam logic [3:0] WORK_NIBBLE = 4'hc;
    localparam int NUM_PAGES = 8;
    localparam int PAGE_W = 3;
    localparam int PHYS_W = 11;
    // ========================================================
    // addressing-mode qualifier from the instruction decoder
    typedef enum logic [2:0] {
        RFM_MODE_REG = 3'b001,
        RFM_MODE_WORK = 3'b010,
        RFM_MODE_IND = 3'b100
    } rfm_mode_t;
    // target region of a decoded access
    typedef enum logic [5:0] {
        RFM_TGT_PRIME = 6'b000001,
        RFM_TGT_COMMON = 6'b000010,
        RFM_TGT_SYS = 6'b000100,
        RFM_TGT_BANK = 6'b001000,
        RFM_TGT_SET2 = 6'b010000,
        RFM_TGT_NONE = 6'b100000
    } rfm_tgt_t;
endpackage

// file: rfm_work_addr.sv
// working-register address former: slice pointer joined with the low bits
// assumes pointers come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module rfm_work_addr
    import rfm_pkg::*;
(
    input wire logic [3:0] work_idx, // 4-bit working address
    input wire logic [7:0] sp_first, // first slice pointer
    input wire logic [7:0] sp_second, // second slice pointer
    output logic [7:0] reg_addr // formed register address
);
    // bit 3 picks the pointer; its upper five bits name the slice
    always_comb begin
        if (work_idx[3]) begin
            reg_addr = {sp_second[7:3], work_idx[2:0]};
        end else begin
            reg_addr = {sp_first[7:3], work_idx[2:0]};
        end
    end
endmodule
`default_nettype wire

// file: rfm_cpu_model.sv
// cpu-side partner: fetch control, register accesses and pointer instructions
// assumes the bench calls its tasks; every drive lands just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module rfm_cpu_model
    import rfm_pkg::*;
(
    input wire logic clk, // core clock
    output logic pc_load, // fetch address load
    output logic [15:0] pc_load_val, // new fetch address
    output logic pc_step, // fetch advance
    output logic rb_req, // register access
    output logic rb_we, // write
    output logic rb_pair, // pair access
    output logic [2:0] rb_mode, // addressing mode
    output logic rb_short, // 4-bit working form
    output logic [7:0] rb_addr, // register address
    output logic [7:0] rb_wdata, // write data
    output logic [4:0] instr, // bank0, bank1, both, first, second
    output logic [7:0] srp_operand // pointer operand
);
    initial begin
        {pc_load, pc_step, rb_req, rb_we, rb_pair, rb_short} = 6'h00;
        {pc_load_val, rb_addr, rb_wdata, srp_operand} = 40'h0;
        rb_mode = RFM_MODE_REG;
        instr = 5'h00;
    end
    // ========================================================
    // fetch control
    task automatic pc_op(input logic [15:0] v, input logic step);
        @(posedge clk);
        pc_load <= ~step;
        pc_step <= step;
        pc_load_val <= v;
        @(posedge clk);
        pc_load <= 1'b0;
        pc_step <= 1'b0;
        pc_load_val <= ~v; // released value is not held
        #1;
    endtask
    // ========================================================
    // register access, one request per call
    task automatic reg_acc(input logic we, input logic pair, input logic [2:0] mode, input logic short,
                           input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        rb_req <= 1'b1;
        rb_we <= we;
        rb_pair <= pair;
        rb_mode <= mode; // qualifier goes with every access
        rb_short <= short;
        rb_addr <= addr;
        rb_wdata <= wdata;
        @(posedge clk);
        rb_req <= 1'b0;
        rb_addr <= ~addr; // released bus shows garbage
        rb_wdata <= ~wdata;
        #1;
    endtask
    // ========================================================
    // pointer and bank instructions
    task automatic do_instr(input logic [4:0] k, input logic [7:0] op);
        @(posedge clk);
        instr <= k;
        srp_operand <= op;
        @(posedge clk);
        instr <= 5'h00;
        srp_operand <= ~op;
        #1;
    endtask
endmodule
`default_nettype wire

// file: rfm_addr_map_tb.sv
// self-checking bench for the register file address map
// assumes the cpu partner model drives every design input except clk and srst, which the bench drives
`timescale 1ns/1ps
`default_nettype none
module rfm_addr_map_tb
    import rfm_pkg::*;
;
    logic clk, srst, pc_load, pc_step, rb_req, rb_we, rb_pair, rb_short;
    logic [15:0] pc_load_val, fetch_addr;
    logic [2:0] rb_mode;
    logic [7:0] rb_addr, rb_wdata, rb_rdata, srp_operand, sp1, sp2, pp;
    logic [4:0] instr;
    logic fetch_valid, fetch_in_vec, rb_hit_ptr, phys_bank, phys_err, phys_valid, bank_sel;
    logic [PHYS_W-1:0] phys_addr, phys_addr_lo;
    logic [5:0] phys_tgt;
    int fail_count = 0;
    int tests_run = 0;

    rfm_addr_map rfm_addr_map_i (.clk(clk), .srst(srst), .pc_load(pc_load), .pc_load_val(pc_load_val),
        .pc_step(pc_step), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_in_vec(fetch_in_vec),
        .rb_req(rb_req), .rb_we(rb_we), .rb_pair(rb_pair), .rb_mode(rb_mode), .rb_short(rb_short),
        .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_rdata(rb_rdata), .rb_hit_ptr(rb_hit_ptr),
        .bank_zero_select_instr(instr[4]), .bank_one_select_instr(instr[3]),
        .set_both_slice_pointers(instr[2]), .set_first_slice_pointer(instr[1]),
        .set_second_slice_pointer(instr[0]), .srp_operand(srp_operand), .phys_addr(phys_addr),
        .phys_addr_lo(phys_addr_lo), .phys_tgt(phys_tgt), .phys_bank(phys_bank), .phys_err(phys_err),
        .phys_valid(phys_valid), .slice_pointer_first(sp1), .slice_pointer_second(sp2),
        .page_select_pointer(pp), .bank_sel(bank_sel));

    rfm_cpu_model rfm_cpu_model_i (.clk(clk), .pc_load(pc_load), .pc_load_val(pc_load_val),
        .pc_step(pc_step), .rb_req(rb_req), .rb_we(rb_we), .rb_pair(rb_pair), .rb_mode(rb_mode),
        .rb_short(rb_short), .rb_addr(rb_addr), .rb_wdata(rb_wdata), .instr(instr),
        .srp_operand(srp_operand));

    // ========================================================
    // clock, verdict and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // read access and its decoded target in one step
    task automatic rd(input logic [2:0] mode, input logic short, input logic [7:0] a, input logic [5:0] tgt);
        rfm_cpu_model_i.reg_acc(1'b0, 1'b0, mode, short, a, 8'h00);
        chk("phys_valid", 16'h1, {15'h0, phys_valid});
        chk("phys_err", 16'h0, {15'h0, phys_err});
        chk("phys_tgt", {10'h0, tgt}, {10'h0, phys_tgt});
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // ========================================================
    // main sequence
    initial begin
        srst = 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("fetch_addr", RESET_PC, fetch_addr);
        chk("fetch_in_vec", 16'h0, {15'h0, fetch_in_vec});
        chk("pointers", {RST_SP_FIRST, RST_SP_SECOND}, {sp1, sp2});
        chk("page ptr and bank", 16'h0, {pp, 7'h0, bank_sel});
        // vector area boundary and top of program memory
        rfm_cpu_model_i.pc_op(16'h00ff, 1'b0);
        chk("vector fetch", 16'h3, {14'h0, fetch_valid, fetch_in_vec});
        rfm_cpu_model_i.pc_op(16'hbfff, 1'b0);
        chk("last rom fetch", 16'h2, {14'h0, fetch_valid, fetch_in_vec});
        rfm_cpu_model_i.pc_op(16'h0000, 1'b1);
        chk("past rom fetch", {16'hc000}, fetch_addr);
        chk("past rom valid", 16'h0, {15'h0, fetch_valid});
        // pointer registers over the register bus
        rd(RFM_MODE_REG, 1'b0, ADDR_SP_FIRST, RFM_TGT_SYS);
        chk("rb_rdata", {7'h0, 1'b1, RST_SP_FIRST}, {7'h0, rb_hit_ptr, rb_rdata});
        // page pointer set before any paged access
        rfm_cpu_model_i.reg_acc(1'b1, 1'b0, RFM_MODE_REG, 1'b0, ADDR_PAGE_PTR, 8'h21);
        chk("page_select_pointer", 16'h0021, {8'h0, pp});
        rd(RFM_MODE_REG, 1'b0, 8'h45, RFM_TGT_PRIME);
        chk("prime read page", 16'h0145, {5'h0, phys_addr});
        rfm_cpu_model_i.reg_acc(1'b1, 1'b0, RFM_MODE_IND, 1'b0, 8'hbf, 8'h5a);
        chk("prime write page", 16'h02bf, {5'h0, phys_addr});
        rd(RFM_MODE_IND, 1'b0, 8'hc5, RFM_TGT_SET2);
        chk("set2 page", 16'h01c5, {5'h0, phys_addr});
        rd(RFM_MODE_REG, 1'b0, 8'hc3, RFM_TGT_COMMON);
        chk("common byte", 16'h00c3, {8'h0, phys_addr[7:0]});
        // bank selection
        rfm_cpu_model_i.do_instr(5'h08, 8'h00);
        chk("bank_sel", 16'h1, {15'h0, bank_sel});
        rd(RFM_MODE_REG, 1'b0, 8'he5, RFM_TGT_BANK);
        chk("phys_bank", 16'h1, {15'h0, phys_bank});
        rfm_cpu_model_i.do_instr(5'h10, 8'h00);
        chk("bank_sel", 16'h0, {15'h0, bank_sel});
        // pointer instructions
        rfm_cpu_model_i.do_instr(5'h04, 8'h70);
        chk("set both", 16'h7078, {sp1, sp2});
        rfm_cpu_model_i.do_instr(5'h01, 8'h48);
        chk("set second", 16'h7048, {sp1, sp2});
        rfm_cpu_model_i.do_instr(5'h02, 8'ha0);
        chk("set first", 16'ha048, {sp1, sp2});
        rd(RFM_MODE_WORK, 1'b1, 8'h06, RFM_TGT_PRIME);
        chk("work first", 16'h00a6, {8'h0, phys_addr[7:0]});
        rd(RFM_MODE_WORK, 1'b1, 8'h0e, RFM_TGT_PRIME);
        chk("work second", 16'h004e, {8'h0, phys_addr[7:0]});
        rfm_cpu_model_i.do_instr(5'h02, 8'hf0);
        rd(RFM_MODE_WORK, 1'b1, 8'h02, RFM_TGT_BANK);
        // pair and pointer load over the bus
        rfm_cpu_model_i.reg_acc(1'b0, 1'b1, RFM_MODE_REG, 1'b0, 8'h45, 8'h00);
        chk("pair bytes", 16'h4445, {phys_addr[7:0], phys_addr_lo[7:0]});
        rfm_cpu_model_i.reg_acc(1'b1, 1'b0, RFM_MODE_REG, 1'b0, ADDR_SP_SECOND, 8'h99);
        chk("bus load second", 16'hf099, {sp1, sp2});
        rd(RFM_MODE_REG, 1'b0, ADDR_SP_SECOND, RFM_TGT_SYS);
        chk("rb_rdata", 16'h0199, {7'h0, rb_hit_ptr, rb_rdata});
        // second reset with every pointer and the fetch address moved away from reset values
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("fetch_addr again", RESET_PC, fetch_addr);
        chk("pointers again", {RST_SP_FIRST, RST_SP_SECOND}, {sp1, sp2});
        chk("page ptr again", 16'h0, {pp, 7'h0, bank_sel});
        print_verdict();
    end
endmodule
`default_nettype wire
